// ### verilog/owd_pkg.sv
package owd_pkg;
  // register byte addresses: printed sfr offsets are not all multiples of
  // four, so each printed offset is an index and byte address is 4x
  localparam logic [7:0] AUX_CONTROL_IDX = 8'h8e;
  localparam logic [7:0] WATCHDOG_SERVICE_IDX = 8'ha6;
  localparam logic [7:0] POWER_CTRL_IDX = 8'h87;  // mode/status word
  localparam logic [9:0] AUX_CONTROL_ADDR = {AUX_CONTROL_IDX, 2'b00};
  localparam logic [9:0] WATCHDOG_SERVICE_ADDR = {WATCHDOG_SERVICE_IDX, 2'b00};
  localparam logic [9:0] POWER_CTRL_ADDR = {POWER_CTRL_IDX, 2'b00};
  // service key bytes
  localparam logic [7:0] KEY_FIRST = 8'h1e;
  localparam logic [7:0] KEY_SECOND = 8'he1;
  // field positions
  localparam int IDLE_STOP_BIT = 4;    // in aux_control_reg
  localparam int IDLE_BIT = 0;         // in power_ctrl
  localparam int PDOWN_BIT = 1;        // in power_ctrl
  localparam int ARMED_BIT = 7;        // in power_ctrl, read only
  localparam logic [7:0] AUX_RESET = 8'h00;
  // counter and timing
  localparam int CNT_W = 14;
  localparam logic [13:0] CNT_MAX = 14'h3fff;
  localparam int OSC_PER_MC = 12;      // oscillator periods per machine cycle
  localparam int PULSE_OSC = 98;       // reset pulse, oscillator periods
  localparam int OSC_PER_CLK = 1;      // sys_clk is the oscillator
  localparam int PULSE_CYC = (PULSE_OSC + OSC_PER_CLK - 1) / OSC_PER_CLK;
  // key matcher states
  typedef enum logic [0:0] {
    OWD_KEY_WAIT = 1'b0,
    OWD_KEY_HALF = 1'b1
  } owd_key_t;
endpackage : owd_pkg

// ### verilog/owd_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - comes out of reset disabled, not counting
// - 1e then e1 to service register arms
// - armed counter advances every machine cycle
// - 14-bit count overflows at 3fff, resets device
// - stays armed until any reset
// - key clears counter; software services often enough
// - service register write only; counter hidden
// - overflow drives reset high 98 oscillator periods
// - power-down halts counter, value held
// - after power-down, wait for irq pin high
// - idle-stop clear: keeps counting in idle
// - idle-stop set: freezes in idle, resumes after
module owd_watchdog #(
  parameter int MC_DIV = owd_pkg::OSC_PER_MC,  // oscillator per machine cycle
  parameter int PULSE_LEN = owd_pkg::PULSE_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // wake pins, active low level interrupts
  input wire logic ext_irq_zero_n_in,
  input wire logic ext_irq_one_n_in,
  // watchdog reset pin drive
  output logic wdt_reset_out
);

  // address phase capture
  logic wr_pend_ff, nxt_wr_pend;
  logic [9:0] addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  // block state
  logic [7:0] aux_ff, nxt_aux;           // aux_control_reg
  logic idle_ff, nxt_idle;               // core idle
  logic pdown_ff, nxt_pdown;             // oscillator stopped
  logic wake_hold_ff, nxt_wake_hold;     // waiting for irq pin high
  logic armed_ff, nxt_armed;
  owd_pkg::owd_key_t key_ff, nxt_key;    // key matcher state
  logic [13:0] cnt_ff, nxt_cnt;          // watchdog_counter
  logic [7:0] div_ff, nxt_div;           // machine cycle divider
  logic [7:0] pulse_ff, nxt_pulse;       // reset pulse length
  logic mc_tick;
  logic count_en;
  logic key_hit;
  logic svc_wr;
  logic aux_wr;
  logic pwr_wr;
  logic irq_low;
  logic [7:0] wbyte;

  // write decode, used more than once
  function automatic logic wr_to(input logic [9:0] a, input logic [9:0] t);
    wr_to = (a == t);
  endfunction : wr_to

  assign wbyte = hwdata_in[7:0];
  assign irq_low = !ext_irq_zero_n_in || !ext_irq_one_n_in;
  assign svc_wr = wr_pend_ff && wr_to(addr_ff, owd_pkg::WATCHDOG_SERVICE_ADDR);
  assign aux_wr = wr_pend_ff && wr_to(addr_ff, owd_pkg::AUX_CONTROL_ADDR);
  assign pwr_wr = wr_pend_ff && wr_to(addr_ff, owd_pkg::POWER_CTRL_ADDR);
  // zero wait states, always okay
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_ff;

  // bus phase tracking and read mux
  always_comb
  begin
    nxt_wr_pend = 1'b0;
    nxt_addr = addr_ff;
    nxt_rdata = rdata_ff;
    if (hsel_in && hready_in && htrans_in[1])
    begin
      nxt_wr_pend = hwrite_in;
      nxt_addr = haddr_in[9:0];
      nxt_rdata = 32'h0000_0000;
      // counter and service register read as zero
      if (haddr_in[9:0] == owd_pkg::AUX_CONTROL_ADDR)
      begin
        nxt_rdata = {24'h00_0000, aux_ff};
      end
      else if (haddr_in[9:0] == owd_pkg::POWER_CTRL_ADDR)
      begin
        nxt_rdata = {24'h00_0000, armed_ff, 5'h00, pdown_ff, idle_ff};
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 10'h000;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
      rdata_ff <= nxt_rdata;
    end
  end

  // key match: 1e immediately followed by e1 on the service register
  always_comb
  begin
    nxt_key = key_ff;
    key_hit = 1'b0;
    if (svc_wr)
    begin
      case (key_ff)
        owd_pkg::OWD_KEY_WAIT:
        begin
          nxt_key = (wbyte == owd_pkg::KEY_FIRST) ? owd_pkg::OWD_KEY_HALF
                                                  : owd_pkg::OWD_KEY_WAIT;
        end
        owd_pkg::OWD_KEY_HALF:
        begin
          // any other value restarts matching
          key_hit = (wbyte == owd_pkg::KEY_SECOND);
          nxt_key = (wbyte == owd_pkg::KEY_FIRST) ? owd_pkg::OWD_KEY_HALF
                                                  : owd_pkg::OWD_KEY_WAIT;
        end
        default:
        begin
          nxt_key = owd_pkg::OWD_KEY_WAIT;
        end
      endcase
    end
    else if (wr_pend_ff)
    begin
      // a write elsewhere breaks the pair
      nxt_key = owd_pkg::OWD_KEY_WAIT;
    end
  end

  // counting permitted: oscillator running and not frozen
  assign count_en = armed_ff && !pdown_ff && !wake_hold_ff
    && !(idle_ff && aux_ff[owd_pkg::IDLE_STOP_BIT]);
  assign mc_tick = (div_ff == 8'(MC_DIV - 1));

  // mode, arming, counter, divider and pulse
  always_comb
  begin
    nxt_aux = aux_ff;
    nxt_idle = idle_ff;
    nxt_pdown = pdown_ff;
    nxt_wake_hold = wake_hold_ff;
    nxt_armed = armed_ff;
    nxt_cnt = cnt_ff;
    nxt_div = div_ff;
    nxt_pulse = (pulse_ff != 8'h00) ? pulse_ff - 8'h01 : 8'h00;
    if (aux_wr)
    begin
      nxt_aux = wbyte;
    end
    if (pwr_wr)
    begin
      nxt_idle = wbyte[owd_pkg::IDLE_BIT];
      nxt_pdown = wbyte[owd_pkg::PDOWN_BIT];
    end
    // level interrupt ends idle or power-down; after power-down count waits for high
    if (pdown_ff && irq_low)
    begin
      nxt_pdown = 1'b0;
      nxt_idle = 1'b0;
      nxt_wake_hold = 1'b1;
    end
    if (wake_hold_ff && !irq_low)
    begin
      nxt_wake_hold = 1'b0;
    end
    if (idle_ff && irq_low && !pdown_ff)
    begin
      nxt_idle = 1'b0;
    end
    if (count_en)
    begin
      nxt_div = mc_tick ? 8'h00 : div_ff + 8'h01;
      if (mc_tick)
      begin
        nxt_cnt = cnt_ff + 14'h0001;
      end
    end
    if (key_hit)
    begin
      nxt_armed = 1'b1;
      nxt_cnt = 14'h0000;
      nxt_div = 8'h00;
    end
    else if (count_en && mc_tick && cnt_ff == owd_pkg::CNT_MAX)
    begin
      // overflow: pulse pin and return to disabled
      nxt_pulse = 8'(PULSE_LEN);
      nxt_armed = 1'b0;
      nxt_cnt = 14'h0000;
      nxt_div = 8'h00;
      nxt_aux = owd_pkg::AUX_RESET;
      nxt_idle = 1'b0;
      nxt_pdown = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      aux_ff <= owd_pkg::AUX_RESET;
      idle_ff <= 1'b0;
      pdown_ff <= 1'b0;
      wake_hold_ff <= 1'b0;
      armed_ff <= 1'b0;
      key_ff <= owd_pkg::OWD_KEY_WAIT;
      cnt_ff <= 14'h0000;
      div_ff <= 8'h00;
      pulse_ff <= 8'h00;
    end
    else
    begin
      aux_ff <= nxt_aux;
      idle_ff <= nxt_idle;
      pdown_ff <= nxt_pdown;
      wake_hold_ff <= nxt_wake_hold;
      armed_ff <= nxt_armed;
      key_ff <= nxt_key;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
      pulse_ff <= nxt_pulse;
    end
  end

  // pin high while pulse count runs
  assign wdt_reset_out = (pulse_ff != 8'h00);

  // assertions
  a_disabled_no_count: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    !armed_ff && !key_hit |=> cnt_ff == 14'h0000)
    else $error("counter moved while disabled");

  a_key_arms: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    key_hit |=> armed_ff && cnt_ff == 14'h0000)
    else $error("key did not arm");

  a_mc_increment: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    count_en && mc_tick && !key_hit && cnt_ff != owd_pkg::CNT_MAX
    |=> cnt_ff == $past(cnt_ff) + 14'h0001)
    else $error("counter missed a machine cycle");

  a_overflow_pulse: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    count_en && mc_tick && !key_hit && cnt_ff == owd_pkg::CNT_MAX
    |=> wdt_reset_out && !armed_ff)
    else $error("overflow did not reset");

  a_stays_armed: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    armed_ff && !wdt_reset_out ##1 !wdt_reset_out |-> armed_ff)
    else $error("watchdog disarmed without reset");

  sequence s_pulse_start;
    !wdt_reset_out ##1 wdt_reset_out;
  endsequence
  a_pulse_width: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    s_pulse_start |-> wdt_reset_out [*8])
    else $error("reset pulse too short");

  a_pdown_hold: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    pdown_ff && !key_hit |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved in power-down");

  a_wake_hold: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    wake_hold_ff && !key_hit |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while irq low");

  a_idle_freeze: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    idle_ff && aux_ff[owd_pkg::IDLE_STOP_BIT] && !key_hit
    |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved in stopped idle");

  a_hidden_counter: assert property (
    @(posedge sys_clk_in) disable iff (!rstn_in)
    $past(hsel_in && htrans_in[1] && haddr_in[9:0]
          == owd_pkg::WATCHDOG_SERVICE_ADDR) |-> rdata_ff == 32'h0000_0000)
    else $error("service register readable");

endmodule : owd_watchdog
`default_nettype wire

// ### tb/owd_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // register byte addresses
  localparam logic [9:0] SVC = owd_pkg::WATCHDOG_SERVICE_ADDR;
  localparam logic [9:0] AUX = owd_pkg::AUX_CONTROL_ADDR;
  localparam logic [9:0] PWR = owd_pkg::POWER_CTRL_ADDR;
  logic clk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic irq0_n;
  logic irq1_n;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic wdt_rst;
  wire logic hresp;
  int bad_count = 0;
  int compares = 0;
  int hi_cnt = 0;
  int n;

  // one clock per machine cycle keeps overflow runs short
  owd_watchdog #(.MC_DIV(1)) owd_watchdog_inst (
    .sys_clk_in(clk), .rstn_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .ext_irq_zero_n_in(irq0_n), .ext_irq_one_n_in(irq1_n),
    .wdt_reset_out(wdt_rst));

  // free running oscillator, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // total cycles the reset pin was seen high
  always @(posedge clk)
    if (wdt_rst === 1'b1)
      hi_cnt <= hi_cnt + 1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      compares++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask : check

  // single word transfer; each phase held until ready is sampled high
  task automatic xfer(input logic wr, input logic [9:0] a,
                      input logic [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {22'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
    end
  endtask : xfer

  // two key bytes back to back
  task automatic service;
    begin
      xfer(1'b1, SVC, 32'h1e);
      xfer(1'b1, SVC, 32'he1);
    end
  endtask : service

  task automatic finish_test;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask : finish_test

  // hang guard, a little beyond the ~95k cycles of the sequence
  initial
  begin
    #9800000;
    bad_count++;
    finish_test;
  end

  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    irq0_n = 1'b1;
    irq1_n = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and hidden registers read as zero
    xfer(1'b0, AUX, 32'h0);
    check(rd & 32'h10, 32'h0);
    xfer(1'b0, SVC, 32'h0);
    check(rd, 32'h0);
    check(32'(hresp), 32'h0);
    xfer(1'b1, AUX, 32'h10);
    xfer(1'b0, AUX, 32'h0);
    check(rd & 32'h10, 32'h10);
    // broken key: a foreign write between the bytes must not arm
    xfer(1'b1, SVC, 32'h1e);
    xfer(1'b1, AUX, 32'h0);
    xfer(1'b1, SVC, 32'he1);
    xfer(1'b0, PWR, 32'h0);
    check(rd & 32'h80, 32'h0);
    repeat (16500) @(posedge clk);
    check(hi_cnt, 0);
    // repeated first byte still arms
    xfer(1'b1, SVC, 32'h1e);
    service;
    xfer(1'b0, PWR, 32'h0);
    check(rd & 32'h80, 32'h80);
    xfer(1'b1, PWR, 32'h0);
    xfer(1'b0, PWR, 32'h0);
    check(rd & 32'h80, 32'h80);
    // timely services keep the pin quiet past one full period
    repeat (9000) @(posedge clk);
    service;
    repeat (9000) @(posedge clk);
    check(hi_cnt, 0);
    // power-down, then wake pin held low: neither may count
    service;
    xfer(1'b1, PWR, 32'h2);
    repeat (9000) @(posedge clk);
    irq0_n <= 1'b0;
    repeat (9000) @(posedge clk);
    irq0_n <= 1'b1;
    service;
    check(hi_cnt, 0);
    // idle with idle-stop set freezes the count
    xfer(1'b1, AUX, 32'h10);
    service;
    xfer(1'b1, PWR, 32'h1);
    repeat (17000) @(posedge clk);
    irq1_n <= 1'b0;
    repeat (2) @(posedge clk);
    irq1_n <= 1'b1;
    service;
    check(hi_cnt, 0);
    // idle with idle-stop clear keeps counting up to overflow;
    // one timer-style wake services it first, so the run restarts
    xfer(1'b1, AUX, 32'h0);
    service;
    xfer(1'b1, PWR, 32'h1);
    repeat (9000) @(posedge clk);
    irq1_n <= 1'b0;
    @(posedge clk);
    irq1_n <= 1'b1;
    service;
    check(hi_cnt, 0);
    xfer(1'b1, PWR, 32'h1);
    n = 2;
    while (wdt_rst !== 1'b1 && n < 17000)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(n > 16378 && n < 16392), 32'h1);
    repeat (120) @(posedge clk);
    check(hi_cnt, owd_pkg::PULSE_CYC);
    xfer(1'b0, PWR, 32'h0);
    check(rd & 32'h80, 32'h0);
    // hardware reset disarms too; re-armed first so the check bites
    service;
    xfer(1'b0, PWR, 32'h0);
    check(rd & 32'h80, 32'h80);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1'b0, PWR, 32'h0);
    check(rd & 32'h80, 32'h0);
    finish_test;
  end
endmodule : testbench
`default_nettype wire
